/* common/csi_params.svh */
// Offsets, field positions, reset values and timing for the change-of-state block
`ifndef CSI_PARAMS_SVH
`define CSI_PARAMS_SVH

// ======================================================================
// Byte offsets inside the 16-byte I/O window
`define CSI_OFF_FET_0       4'h0
`define CSI_OFF_FET_1       4'h1
`define CSI_OFF_FET_2       4'h2
`define CSI_OFF_PORT_DATA   4'h3
`define CSI_OFF_IN_0        4'h4
`define CSI_OFF_IN_1        4'h5
`define CSI_OFF_IN_2        4'h6
`define CSI_OFF_PORT_IN     4'h7
`define CSI_OFF_STAT_0      4'h8
`define CSI_OFF_STAT_1      4'h9
`define CSI_OFF_STAT_2      4'ha
`define CSI_OFF_STAT_3      4'hb
`define CSI_OFF_CTRL        4'hc
`define CSI_OFF_RSVD        4'hd
`define CSI_OFF_EDGE_EN     4'he
`define CSI_OFF_IRQ_RST     4'hf

// ======================================================================
// Reset values and masks
`define CSI_CTRL_RESET      8'h01
`define CSI_CTRL_MASK       8'h0f
`define CSI_EDGE_RESET      8'h00
`define CSI_ZERO_BYTE       8'h00

// ======================================================================
// Line layout
`define CSI_NUM_ISO         24
`define CSI_NUM_LINES       32
`define CSI_GROUP_SIZE      8
`define CSI_FILT_SPLIT      12
`define CSI_FALL_BASE       4

// ======================================================================
// Timing
`define CSI_CLK_PERIOD_NS   50
`define CSI_FILTER_NS       1000
`define CSI_PRIME_CYCLES    3

`endif

/* common/csi_pkg.sv */
// Types shared by the change-of-state block and its users
package csi_pkg;

  // ======================================================================
  // Host access to one byte register
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } csi_req_t;

  // ======================================================================
  // Control byte layout, bit 7 down to bit 0
  typedef struct packed {
    logic [3:0] zero;
    logic       filt_hi;
    logic       filt_lo;
    logic       dir_out;
    logic       buf_en;
  } csi_ctrl_t;

  // ======================================================================
  // Edge enable byte layout
  typedef struct packed {
    logic [3:0] fall;
    logic [3:0] rise;
  } csi_edge_en_t;

endpackage

/* core/csi_ctrl.sv */
// Change-of-state detection, interrupt and control registers of the input card
`timescale 1ns/1ps
`include "csi_params.svh"

// What this block does
// - Latch change per line, read back status
// - Write one clears latch, zero keeps it
// - Interrupt drops only when all 32 clear
// - Status bytes at 8 to B, bit0 lowest
// - Control and edge enable read back written
// - Control fields, upper nibble zero, reset 01
// - Rising enables bits 0-3, falling 4-7
// - Group interrupts on rising, falling or both
// - Edge enable resets to zero
// - Interrupt while any enabled change latched
// - Interrupt status bit 0, others zero
// - Write to F resets control, outputs, status
// - Unselected lines keep latching new changes
// - Output mode drives port data, positive logic
// - Switched outputs reset off, data zero
module csi_ctrl #(
  parameter int unsigned FILTER_CYCLES =
    (`CSI_FILTER_NS + `CSI_CLK_PERIOD_NS - 1) / `CSI_CLK_PERIOD_NS,
  parameter int unsigned CNT_W         = 8
) (
  input  wire logic              ref_clk_i,
  input  wire logic              reset_n_i,
  input  wire csi_pkg::csi_req_t host_req_i,
  output logic [7:0]             rd_data_o,
  output logic                   rd_valid_o,
  input  wire logic [23:0]       isolated_sense_line_i,
  input  wire logic [7:0]        logic_level_port_line_i,
  output logic [7:0]             logic_level_port_line_o,
  output logic [7:0]             logic_level_port_line_oe_o,
  output logic [23:0]            fet_switch_line_o,
  output logic                   irq_o
);
  import csi_pkg::*;

  localparam int NL = `CSI_NUM_LINES;

  // ======================================================================
  // Address decode
  function automatic logic hit(input csi_req_t r, input logic [3:0] off);
    return r.wr && (r.addr == off);
  endfunction

  // Clear mask built from a write to any of the four status bytes
  function automatic logic [NL-1:0] clr_mask(input csi_req_t r);
    logic [NL-1:0] m;
    m = '0;
    if (hit(r, `CSI_OFF_STAT_0)) m[7:0]   = r.wdata;
    if (hit(r, `CSI_OFF_STAT_1)) m[15:8]  = r.wdata;
    if (hit(r, `CSI_OFF_STAT_2)) m[23:16] = r.wdata;
    if (hit(r, `CSI_OFF_STAT_3)) m[31:24] = r.wdata;
    return m;
  endfunction

  logic      soft_rst;
  csi_ctrl_t ctrl_q;
  csi_edge_en_t edge_q;
  logic [23:0] fet_q;
  logic [7:0]  port_data_q;

  assign soft_rst = hit(host_req_i, `CSI_OFF_IRQ_RST);

  // ======================================================================
  // Control byte
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= `CSI_CTRL_RESET;
    end else if (soft_rst) begin
      ctrl_q <= `CSI_CTRL_RESET;
    end else if (hit(host_req_i, `CSI_OFF_CTRL)) begin
      ctrl_q <= host_req_i.wdata & `CSI_CTRL_MASK;
    end
  end

  // ======================================================================
  // Edge enable byte; a soft reset leaves it alone
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edge_q <= `CSI_EDGE_RESET;
    end else if (hit(host_req_i, `CSI_OFF_EDGE_EN)) begin
      edge_q <= host_req_i.wdata;
    end
  end

  // ======================================================================
  // Switched outputs and port data
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fet_q       <= '0;
      port_data_q <= `CSI_ZERO_BYTE;
    end else if (soft_rst) begin
      fet_q       <= '0;
      port_data_q <= `CSI_ZERO_BYTE;
    end else begin
      if (hit(host_req_i, `CSI_OFF_FET_0))     fet_q[7:0]   <= host_req_i.wdata;
      if (hit(host_req_i, `CSI_OFF_FET_1))     fet_q[15:8]  <= host_req_i.wdata;
      if (hit(host_req_i, `CSI_OFF_FET_2))     fet_q[23:16] <= host_req_i.wdata;
      if (hit(host_req_i, `CSI_OFF_PORT_DATA)) port_data_q  <= host_req_i.wdata;
    end
  end

  assign fet_switch_line_o          = fet_q;
  assign logic_level_port_line_o    = port_data_q;
  // Driver on only when the buffer is enabled and output mode is chosen
  assign logic_level_port_line_oe_o = {8{ctrl_q.buf_en & ctrl_q.dir_out}};

  // ======================================================================
  // Input synchroniser, three stages
  logic [NL-1:0] s1_q;
  logic [NL-1:0] s2_q;
  logic [NL-1:0] s3_q;
  logic [NL-1:0] raw;

  assign raw = {logic_level_port_line_i, isolated_sense_line_i};

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Filtered levels follow the pins freely until primed, but priming ends one cycle before a pin level reaches them,
  // so a line that sits high at reset release still logs a rising edge
  logic [1:0] prime_q;
  logic       primed;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prime_q <= '0;
    end else if (!primed) begin
      prime_q <= prime_q + 2'h1;
    end
  end

  assign primed = (prime_q == 2'(`CSI_PRIME_CYCLES));

  // ======================================================================
  // Per-line debounce and edge detection
  logic [NL-1:0] filt_q;
  logic [NL-1:0] prev_q;
  logic [NL-1:0] rise;
  logic [NL-1:0] fall;
  logic [NL-1:0] chg;
  logic [NL-1:0] irq_evt;

  // Noise rejection: lines 0-11 on one bit, 12-23 on another, port none
  function automatic logic filt_on(input int i, input csi_ctrl_t c);
    if (i < `CSI_FILT_SPLIT) return c.filt_lo;
    if (i < `CSI_NUM_ISO)    return c.filt_hi;
    return 1'b0;
  endfunction

  for (genvar i = 0; i < NL; i++) begin : g_line
    logic [CNT_W-1:0] cnt_q;
    logic             agree;

    // Only a level that stages two and three agree on is considered
    assign agree = (s2_q[i] == s3_q[i]);

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        cnt_q     <= '0;
        filt_q[i] <= 1'b0;
      end else if (!primed) begin
        cnt_q     <= '0;
        filt_q[i] <= s3_q[i];
      end else if (!agree || (s3_q[i] == filt_q[i])) begin
        cnt_q <= '0;
      end else if (!filt_on(i, ctrl_q)) begin
        filt_q[i] <= s3_q[i];
      end else if (cnt_q >= CNT_W'(FILTER_CYCLES - 1)) begin
        cnt_q     <= '0;
        filt_q[i] <= s3_q[i];
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end

    // Each group of eight uses its own rising and falling enable bit
    assign irq_evt[i] = (rise[i] & edge_q.rise[i / `CSI_GROUP_SIZE]) |
                        (fall[i] & edge_q.fall[i / `CSI_GROUP_SIZE]);
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_q <= '0;
    end else begin
      prev_q <= filt_q;
    end
  end

  assign rise = primed ? (filt_q & ~prev_q) : '0;
  assign fall = primed ? (~filt_q & prev_q) : '0;
  assign chg  = rise | fall;

  // ======================================================================
  // Change status and interrupt-pending latches
  logic [NL-1:0] clr;
  logic [NL-1:0] status_q;
  logic [NL-1:0] status_d;
  logic [NL-1:0] pend_q;
  logic [NL-1:0] pend_d;
  logic          irq_q;

  assign clr = soft_rst ? '1 : clr_mask(host_req_i);

  // New change wins over a same-cycle clear; other lines keep latching
  assign status_d = (status_q & ~clr) | chg;
  assign pend_d   = (pend_q & ~clr) | irq_evt;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_q <= '0;
      pend_q   <= '0;
    end else begin
      status_q <= status_d;
      pend_q   <= pend_d;
    end
  end

  // Pin rises on an enabled edge and holds until all 32 status bits are clear;
  // a change in a disabled group cannot raise it but does keep it up
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (irq_q | (|pend_d)) & (|status_d);
    end
  end

  assign irq_o = irq_q;

  // ======================================================================
  // Read path, answered one cycle after the strobe
  function automatic logic [7:0] rd_mux(input logic [3:0] a);
    case (a)
      `CSI_OFF_FET_0:     return fet_q[7:0];
      `CSI_OFF_FET_1:     return fet_q[15:8];
      `CSI_OFF_FET_2:     return fet_q[23:16];
      `CSI_OFF_PORT_DATA: return port_data_q;
      `CSI_OFF_IN_0:      return filt_q[7:0];
      `CSI_OFF_IN_1:      return filt_q[15:8];
      `CSI_OFF_IN_2:      return filt_q[23:16];
      `CSI_OFF_PORT_IN:   return filt_q[31:24];
      `CSI_OFF_STAT_0:    return status_q[7:0];
      `CSI_OFF_STAT_1:    return status_q[15:8];
      `CSI_OFF_STAT_2:    return status_q[23:16];
      `CSI_OFF_STAT_3:    return status_q[31:24];
      `CSI_OFF_CTRL:      return ctrl_q;
      `CSI_OFF_EDGE_EN:   return edge_q;
      `CSI_OFF_IRQ_RST:   return {7'h00, irq_q};
      default:            return `CSI_ZERO_BYTE;
    endcase
  endfunction

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_data_o  <= `CSI_ZERO_BYTE;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= host_req_i.rd;
      if (host_req_i.rd) begin
        rd_data_o <= rd_mux(host_req_i.addr);
      end
    end
  end

endmodule

/* test/csi_ctrl_props.sv */
// Port-level checks for the change-of-state block
`timescale 1ns/1ps
module csi_ctrl_props (
  input wire logic              ref_clk_i,
  input wire logic              reset_n_i,
  input wire csi_pkg::csi_req_t host_req_i,
  input wire logic [7:0]        rd_data_o,
  input wire logic              rd_valid_o,
  input wire logic [7:0]        logic_level_port_line_o,
  input wire logic [7:0]        logic_level_port_line_oe_o,
  input wire logic [23:0]       fet_switch_line_o,
  input wire logic              irq_o
);
  import csi_pkg::*;
  logic       rd_q;
  logic       clr_q;
  logic [7:0] wd_q;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ======================================================================
  // Helpers, so that past values are taken of whole signals
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_q  <= 1'b0;
      clr_q <= 1'b0;
      wd_q  <= 8'h00;
    end else begin
      rd_q  <= host_req_i.rd;
      clr_q <= host_req_i.wr && (host_req_i.addr[3:2] == 2'b10 || host_req_i.addr == 4'hf);
      wd_q  <= host_req_i.wdata;
    end
  end
  // ======================================================================
  // Assertions
  rd_pulse_a: assert property (rd_valid_o == rd_q)
    else $error("read valid not one cycle after the read");
  irq_read_a: assert property (host_req_i.rd && host_req_i.addr == 4'hf
    |=> rd_data_o == {7'h00, $past(irq_o)}) else $error("irq status byte wrong");
  rsvd_read_a: assert property (host_req_i.rd && host_req_i.addr == 4'hd
    |=> rd_data_o == 8'h00) else $error("reserved byte not zero");
  ctrl_upper_a: assert property (host_req_i.rd && host_req_i.addr == 4'hc
    |=> rd_data_o[7:4] == 4'h0) else $error("control upper bits not zero");
  port_drive_a: assert property (host_req_i.wr && host_req_i.addr == 4'hc
    && host_req_i.wdata[1:0] == 2'b11 |=> logic_level_port_line_oe_o == 8'hff)
    else $error("port not driven in output mode");
  port_data_a: assert property (host_req_i.wr && host_req_i.addr == 4'h3
    |=> logic_level_port_line_o == wd_q) else $error("port data not on pins");
  soft_reset_a: assert property (host_req_i.wr && host_req_i.addr == 4'hf
    |=> fet_switch_line_o == 24'h0 && logic_level_port_line_oe_o == 8'h00
    && logic_level_port_line_o == 8'h00) else $error("outputs not off after soft reset");
  irq_drop_a: assert property ($fell(irq_o) |-> clr_q)
    else $error("interrupt dropped without a clearing write");
endmodule

bind csi_ctrl csi_ctrl_props csi_ctrl_props_inst (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .host_req_i(host_req_i),
  .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .logic_level_port_line_o(logic_level_port_line_o),
  .logic_level_port_line_oe_o(logic_level_port_line_oe_o),
  .fet_switch_line_o(fet_switch_line_o), .irq_o(irq_o));

/* test/csi_ctrl_test.sv */
// Self-checking bench for the change-of-state block
`timescale 1ns/1ps
module csi_ctrl_test;
  import csi_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  csi_req_t    req;
  logic [7:0]  rd_data, port_o, port_oe, d;
  logic        rd_valid, irq;
  logic [23:0] iso = 24'h0, fet;
  logic [7:0]  port_in = 8'h00;
  logic [31:0] s;
  int          err_count = 0;
  int          checks_done = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  csi_ctrl #(.FILTER_CYCLES(2)) csi_ctrl_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .host_req_i(req), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .isolated_sense_line_i(iso), .logic_level_port_line_i(port_in),
    .logic_level_port_line_o(port_o), .logic_level_port_line_oe_o(port_oe),
    .fet_switch_line_o(fet), .irq_o(irq));
  csi_host_model csi_host_model_inst (.ref_clk_i(ref_clk_i), .host_req_o(req),
    .rd_data_i(rd_data), .rd_valid_i(rd_valid));
  // ======================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    csi_host_model_inst.put(1'b1, a, v);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    csi_host_model_inst.get(a, d);
    chk(d, exp);
  endtask
  // Long wait covers synchroniser and debounce
  task automatic line(input int n, input logic v);
    @(posedge ref_clk_i);
    if (n < 24) iso[n] <= v;
    else port_in[n-24] <= v;
    repeat (12) @(posedge ref_clk_i);
  endtask
  // Pulse of len cycles on an isolated line, then time to settle
  task automatic pulse(input int n, input int len);
    @(posedge ref_clk_i);
    iso[n] <= 1'b1;
    repeat (len) @(posedge ref_clk_i);
    iso[n] <= 1'b0;
    repeat (12) @(posedge ref_clk_i);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(negedge ref_clk_i);
    chk(irq, e);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ======================================================================
  // Scenarios
  task automatic t_regs();
    chk(fet, 24'h0);
    rd(4'h0, 8'h00);
    rd(4'hc, 8'h01);
    rd(4'he, 8'h00);
    rd(4'hf, 8'h00);
    wr(4'hc, 8'hff);
    rd(4'hc, 8'h0f);
    wr(4'he, 8'ha5);
    rd(4'he, 8'ha5);
    wr(4'h3, 8'h5a);
    wr(4'hc, 8'h03);
    chk(port_o, 8'h5a);
    chk(port_oe, 8'hff);
    wr(4'hd, 8'hff);
    rd(4'hd, 8'h00);
    wr(4'he, 8'h00);
    $display("register test done");
  endtask
  task automatic t_status();
    line(0, 1'b1);
    line(31, 1'b1);
    line(13, 1'b1);
    rd(4'h8, 8'h01);
    rd(4'h9, 8'h20);
    rd(4'ha, 8'h00);
    rd(4'hb, 8'h80);
    chk(irq, 1'b0);
    wr(4'h8, 8'hfe);
    rd(4'h8, 8'h01);
    wr(4'h8, 8'h01);
    rd(4'h8, 8'h00);
    wr(4'h9, 8'hff);
    wr(4'hb, 8'hff);
    line(0, 1'b0);
    line(31, 1'b0);
    line(13, 1'b0);
    csi_host_model_inst.service(s);
    chk(s, 32'h8000_2001);
    rd(4'h8, 8'h00);
    $display("status test done");
  endtask
  task automatic t_edges();
    for (int g = 0; g < 4; g++) begin
      for (int m = 0; m < 2; m++) begin
        wr(4'he, m ? 8'h10 << g : 8'h01 << g);
        line(g * 9, 1'b1);
        irq_is(!m);
        rd(4'hf, m ? 8'h00 : 8'h01);
        wr(4'h8 + 4'(g), 8'hff);
        irq_is(1'b0);
        line(g * 9, 1'b0);
        irq_is(m);
        wr(4'h8 + 4'(g), 8'hff);
      end
    end
    $display("edge enable test done");
  endtask
  task automatic t_partial();
    wr(4'he, 8'hff);
    line(0, 1'b1);
    line(8, 1'b1);
    rd(4'h8, 8'h01);
    line(1, 1'b1);
    wr(4'h8, 8'h01);
    irq_is(1'b1);
    rd(4'h8, 8'h02);
    wr(4'h9, 8'h01);
    irq_is(1'b1);
    wr(4'h8, 8'h02);
    irq_is(1'b0);
    $display("partial clear test done");
  endtask
  task automatic t_soft();
    wr(4'h0, 8'hff);
    wr(4'hc, 8'h0f);
    chk(fet, 24'h0000ff);
    line(0, 1'b0);
    line(1, 1'b0);
    line(8, 1'b0);
    irq_is(1'b1);
    wr(4'hf, 8'h5a);
    chk(fet, 24'h0);
    chk(port_o, 8'h00);
    chk(port_oe, 8'h00);
    irq_is(1'b0);
    rd(4'hc, 8'h01);
    rd(4'h8, 8'h00);
    rd(4'he, 8'hff);
    $display("soft reset test done");
  endtask
  // A change in a disabled group keeps the pin up after the enabled one clears
  task automatic t_hold();
    wr(4'he, 8'h01);
    line(9, 1'b1);
    line(3, 1'b1);
    irq_is(1'b1);
    wr(4'h8, 8'h08);
    irq_is(1'b1);
    rd(4'h9, 8'h02);
    wr(4'h9, 8'h02);
    irq_is(1'b0);
    line(9, 1'b0);
    line(3, 1'b0);
    irq_is(1'b0);
    wr(4'h8, 8'hff);
    wr(4'h9, 8'hff);
    $display("interrupt hold test done");
  endtask
  // Short pulses are dropped only on lines whose noise rejection is on
  task automatic t_filter();
    wr(4'hc, 8'h05);
    pulse(2, 2);
    rd(4'h8, 8'h00);
    pulse(12, 2);
    rd(4'h9, 8'h10);
    pulse(2, 4);
    rd(4'h8, 8'h04);
    irq_is(1'b1);
    wr(4'h8, 8'h04);
    irq_is(1'b1);
    wr(4'h9, 8'h10);
    irq_is(1'b0);
    $display("filter test done");
  endtask
  // ======================================================================
  // Main sequence and watchdog
  initial begin
    repeat (12) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    t_regs();
    t_status();
    t_edges();
    t_partial();
    t_soft();
    t_hold();
    t_filter();
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    err_count++;
    end_sim();
  end
endmodule

/* test/csi_host_model.sv */
// Host software model issuing byte accesses to the register window
`timescale 1ns/1ps
module csi_host_model (
  input  wire logic         ref_clk_i,
  output csi_pkg::csi_req_t host_req_o,
  input  wire logic [7:0]   rd_data_i,
  input  wire logic         rd_valid_i
);
  import csi_pkg::*;
  initial host_req_o = '0;
  // ======================================================================
  // One access, raised after an edge and dropped at the taking edge
  task automatic put(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    host_req_o <= '{wr: w, rd: !w, addr: a, wdata: v};
    @(posedge ref_clk_i);
    host_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
    @(negedge ref_clk_i);
  endtask
  // Data only counts while the one-cycle valid stands
  task automatic get(input logic [3:0] a, output logic [7:0] v);
    put(1'b0, a, 8'h00);
    v = (rd_valid_i === 1'b1) ? rd_data_i : 8'hxx;
  endtask
  // Reading then writing back the same bits spares later changes
  task automatic service(output logic [31:0] s);
    for (int i = 0; i < 4; i++) begin
      get(4'h8 + 4'(i), s[i*8 +: 8]);
    end
    for (int i = 0; i < 4; i++) begin
      put(1'b1, 4'h8 + 4'(i), s[i*8 +: 8]);
    end
  endtask
endmodule
